// ---- bench/usc_dev_model.sv ----
/* behavioural devices plugged into the two root ports.
 * assumes the bench commands attach and supply fault per port. */
`timescale 1ns/1ps
module usc_dev_model (
    input wire logic [1:0] power_i, // port power drive
    input wire logic [1:0] attach_i, // bench: plug a device
    input wire logic [1:0] fault_i, // bench: short the supply
    output logic [1:0] connect_o, // device present
    output logic [1:0] overcurrent_o, // supply fault sensed
    output logic [3:0] line_levels_o // {dp,dm} per port
);
////////////////////////////////////////////////////////////////
// unpowered device stays silent; host pull-downs then give se0
always_comb begin
    connect_o = attach_i & power_i;
    overcurrent_o = fault_i & power_i;
    for (int p = 0; p < 2; p++) begin
        line_levels_o[2*p+:2] = connect_o[p] ? 2'b01 : 2'b00; // low-speed idle
    end
end
endmodule : usc_dev_model

// ---- bench/usc_port_regs_tb.sv ----
/* self-checking bench for the root port registers.
 * assumes the attached-device model stands on the port side. */
`timescale 1ns/1ps
module usc_port_regs_tb;
import usc_pkg::*;
logic ref_clk_i = 1'b0;
logic rstn_i = 1'b0;
logic hc_reset_i = 1'b0;
logic flag = 1'b0;
logic ce = 1'b1;
logic power_switch_present = 1'b1;
usc_req_t req_i = '0;
logic [1:0] attach = 2'b00;
logic [1:0] fault = 2'b00;
logic [31:0] rdata_o;
logic [1:0] connect, oc, wake_o, power_o, owner_o;
logic [3:0] lines;
logic [7:0] test_o;
int n_mismatch = 0;
int checks_done = 0;
////////////////////////////////////////////////////////////////
// 50 MHz clock
always #10 ref_clk_i = ~ref_clk_i;
usc_port_regs #(.NUM_PORTS(2)) u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce),
    .hc_reset_i(hc_reset_i), .req_i(req_i), .rdata_o(rdata_o),
    .configure_done_flag_i(flag), .power_switch_present_i(power_switch_present), .connect_i(connect),
    .overcurrent_i(oc), .line_levels_i(lines), .wake_o(wake_o),
    .port_test_select_o(test_o), .port_power_on_o(power_o), .companion_owns_port_o(owner_o));
usc_dev_model u_dev (.power_i(power_o), .attach_i(attach), .fault_i(fault),
    .connect_o(connect), .overcurrent_o(oc), .line_levels_o(lines));
////////////////////////////////////////////////////////////////
task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
        n_mismatch++;
        $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
endtask : chk
task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    req_i <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk_i);
    req_i <= '0;
    #1;
endtask : wr
task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge ref_clk_i);
    req_i <= '{wr: 1'b0, addr: a, wdata: 32'h0000_0000};
    @(posedge ref_clk_i);
    #1;
    chk(rdata_o & m, exp);
endtask : rchk
task cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
endtask : cyc
task set_dev(input logic [1:0] a, input logic [1:0] f);
    @(posedge ref_clk_i);
    attach <= a;
    fault <= f;
endtask : set_dev
task wake_chk(input int p, input logic exp);
    logic s;
    s = 1'b0;
    repeat (8) begin
        @(posedge ref_clk_i);
        #1;
        if (wake_o[p] === 1'b1) s = 1'b1;
    end
    chk(32'(s), 32'(exp));
endtask : wake_chk
////////////////////////////////////////////////////////////////
task t_reset;
    rchk(8'h64, 32'hffff_ffff, 32'h0000_2000);
    rchk(8'h68, 32'hffff_ffff, 32'h0000_2000);
    rchk(8'h6c, 32'hffff_ffff, 32'h0000_0000);
    chk(32'({power_o, test_o}), 32'h0000_0000);
    $display("test reset done");
endtask : t_reset
task t_frozen;
    wr(8'h64, 32'h0074_0000);
    rchk(8'h64, 32'hffff_ffff, 32'h0000_2000);
    wr(8'h64, 32'h0000_1000);
    wr(8'h68, 32'h0000_1000);
    chk(32'(power_o), 32'h0000_0003);
    cyc(4);
    wr(8'h64, 32'h0074_3000);
    rchk(8'h64, 32'hffff_ffff, 32'h0074_3000);
    chk(32'(test_o[3:0]), 32'h0000_0004);
    $display("test frozen done");
endtask : t_frozen
task t_codes;
    logic [31:0] v;
    for (int c = 0; c < 5; c++) begin
        v = 32'h0000_3000 | (32'(c) << 16);
        wr(8'h68, v);
        rchk(8'h68, 32'hffff_ffff, v);
        chk(32'(test_o[7:4]), 32'(c));
    end
    $display("test codes done");
endtask : t_codes
task t_wake;
    wr(8'h64, 32'h0070_3000);
    set_dev(2'b01, 2'b00);
    wake_chk(0, 1'b1);
    rchk(8'h64, 32'h0000_0c05, 32'h0000_0401);
    set_dev(2'b11, 2'b00);
    wake_chk(1, 1'b0);
    set_dev(2'b10, 2'b00);
    wake_chk(0, 1'b1);
    set_dev(2'b10, 2'b01);
    wake_chk(0, 1'b1);
    chk(32'(power_o[0]), 32'h0000_0000);
    set_dev(2'b00, 2'b00);
    $display("test wake done");
endtask : t_wake
task t_owner;
    chk(32'(owner_o), 32'h0000_0003);
    @(posedge ref_clk_i);
    flag <= 1'b1;
    cyc(3);
    chk(32'(owner_o), 32'h0000_0000);
    rchk(8'h64, 32'h0000_2000, 32'h0000_0000);
    @(posedge ref_clk_i);
    flag <= 1'b0;
    cyc(3);
    chk(32'(owner_o), 32'h0000_0003);
    $display("test owner done");
endtask : t_owner
task t_hcreset;
    wr(8'h68, 32'h0074_3000);
    @(posedge ref_clk_i);
    hc_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    hc_reset_i <= 1'b0;
    cyc(2);
    rchk(8'h68, 32'hffff_ffff, 32'h0000_2000);
    chk(32'(test_o), 32'h0000_0000);
    $display("test hc reset done");
endtask : t_hcreset
// no power switches, clock enable low, port enable, then a mid-run aux reset
task t_misc;
    @(posedge ref_clk_i);
    power_switch_present <= 1'b0;
    wr(8'h64, 32'h0003_2000);
    rchk(8'h64, 32'hffff_ffff, 32'h0003_3000);
    chk(32'(power_o), 32'h0000_0003);
    @(posedge ref_clk_i);
    ce <= 1'b0;
    wr(8'h64, 32'h0000_2000);
    @(posedge ref_clk_i);
    ce <= 1'b1;
    rchk(8'h64, 32'h000f_0000, 32'h0003_0000);
    set_dev(2'b01, 2'b00);
    cyc(2);
    wr(8'h64, 32'h0000_3004);
    rchk(8'h64, 32'h0000_0c05, 32'h0000_0005);
    set_dev(2'b00, 2'b00);
    @(posedge ref_clk_i);
    power_switch_present <= 1'b1;
    rstn_i <= 1'b0;
    cyc(2);
    @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rchk(8'h64, 32'hffff_ffff, 32'h0000_2000);
    rchk(8'h68, 32'hffff_ffff, 32'h0000_2000);
    $display("test misc done");
endtask : t_misc
task complete_run;
    $display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
        $display("Result: passed");
    end else begin
        $display("Result: failed");
    end
    $finish;
endtask : complete_run
////////////////////////////////////////////////////////////////
// main sequence after a 16-cycle reset
initial begin
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_frozen();
    t_codes();
    t_wake();
    t_owner();
    t_hcreset();
    t_misc();
    complete_run();
end
// watchdog, far beyond the roughly 150 cycles the tests need
initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_mismatch++;
    complete_run();
end
endmodule : usc_port_regs_tb

// ---- src/usc_pkg.sv ----
/*
 * constants, field layout and carrier types for the root port status/control bank.
 * assumes a plain word-wide register access port and one 50 MHz clock.
 */
// Summary of operation
// - port registers reset only by aux power-up or host controller reset.
// - after reset each port reads not connected and disabled.
// - with power switches, port state other than the owner bit is frozen until software turns power on.
// - port n register sits at base plus 64h plus four times (n minus 1).
// - bit 22 enables overcurrent as wake event, reset 0.
// - bit 21 enables disconnect as wake event, reset 0.
// - bit 20 enables connect as wake event, reset 0.
// - bits 19..16 select test mode, zero means normal, reset 0000b.
// - test codes 1 J, 2 K, 3 SE0_NAK, 4 test packet.
// - owner bit defaults 1, clears on flag rise, forced 1 while flag low.
// - overcurrent on powered switched port clears the power bit.
// - line levels bits 11..10 valid only when disabled and connected.
package usc_pkg;
    localparam int USC_ADDR_W = 8;
    localparam logic [7:0] USC_PORT_BASE = 8'h64;
    localparam logic [7:0] USC_PORT_STRIDE = 8'h04;
    localparam int USC_B_CONNECT = 0;
    localparam int USC_B_ENABLE = 2;
    localparam int USC_B_LINE_LO = 10;
    localparam int USC_B_POWER = 12;
    localparam int USC_B_OWNER = 13;
    localparam int USC_B_TEST_LO = 16;
    localparam int USC_B_WK_CONN = 20;
    localparam int USC_B_WK_DISC = 21;
    localparam int USC_B_WK_OC = 22;
    localparam logic [3:0] USC_TEST_OFF = 4'h0;
    localparam logic [3:0] USC_TEST_J = 4'h1;
    localparam logic [3:0] USC_TEST_K = 4'h2;
    localparam logic [3:0] USC_TEST_SE0_NAK = 4'h3;
    localparam logic [3:0] USC_TEST_PACKET = 4'h4;
    localparam logic [1:0] USC_LINE_NONE = 2'h0;

    // per-port stored fields
    typedef struct packed {
        logic wake_overcurrent_enable;
        logic wake_disconnect_enable;
        logic wake_connect_enable;
        logic [3:0] port_test_select;
        logic companion_owns_port;
        logic port_power_on;
        logic connected;
        logic enabled;
        logic oc_seen;
    } usc_port_t;

    localparam usc_port_t USC_PORT_RST = '{
        wake_overcurrent_enable: 1'b0, wake_disconnect_enable: 1'b0,
        wake_connect_enable: 1'b0, port_test_select: 4'h0,
        companion_owns_port: 1'b1, port_power_on: 1'b0,
        connected: 1'b0, enabled: 1'b0, oc_seen: 1'b0};

    // register access request
    typedef struct packed {
        logic wr;
        logic [USC_ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } usc_req_t;
endpackage : usc_pkg

// ---- src/usc_port_regs.sv ----
/*
 * status/control registers of the downstream root ports, with wake detection
 * and test-mode selection. assumes requests synchronous to ref_clk_i.
 */
`timescale 1ns/1ps
module usc_port_regs #(
    parameter int NUM_PORTS = 2
) (
    input wire logic ref_clk_i, // 50 MHz clock
    input wire logic rstn_i, // aux power-up reset
    input wire logic ce_i, // clock enable
    input wire logic hc_reset_i, // host controller reset
    input wire usc_pkg::usc_req_t req_i, // register request
    output logic [31:0] rdata_o, // read data, one cycle later
    input wire logic configure_done_flag_i, // configure flag
    input wire logic power_switch_present_i, // power switches fitted
    input wire logic [NUM_PORTS-1:0] connect_i, // device attached
    input wire logic [NUM_PORTS-1:0] overcurrent_i, // overcurrent sensed
    input wire logic [2*NUM_PORTS-1:0] line_levels_i, // dp,dm per port
    output logic [NUM_PORTS-1:0] wake_o, // wake event pulse
    output logic [4*NUM_PORTS-1:0] port_test_select_o, // test mode per port
    output logic [NUM_PORTS-1:0] port_power_on_o, // power switch drive
    output logic [NUM_PORTS-1:0] companion_owns_port_o // routed to companion
);
    import usc_pkg::*;

    // only one or two root ports are decoded
    if (NUM_PORTS < 1 || NUM_PORTS > 2) begin : g_bad_ports
        $error("NUM_PORTS must be 1 or 2");
    end

    typedef struct packed {
        usc_port_t [NUM_PORTS-1:0] port;
        logic cf_q;
        logic [31:0] rdata;
        logic [NUM_PORTS-1:0] wake;
    } usc_state_t;

    usc_state_t st;
    usc_state_t next_st;

    // address of port n (0-based)
    function automatic logic [USC_ADDR_W-1:0] port_addr(input int n);
        port_addr = USC_PORT_BASE + USC_PORT_STRIDE * n[USC_ADDR_W-1:0];
    endfunction : port_addr

    // read image of one port
    function automatic logic [31:0] port_image(input usc_port_t p, input logic [1:0] ln,
                                               input logic power_switch_present);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[USC_B_CONNECT] = p.connected;
        v[USC_B_ENABLE] = p.enabled;
        v[USC_B_LINE_LO +: 2] = (p.connected && !p.enabled) ? ln : USC_LINE_NONE;
        v[USC_B_POWER] = p.port_power_on | ~power_switch_present;
        v[USC_B_OWNER] = p.companion_owns_port;
        v[USC_B_TEST_LO +: 4] = p.port_test_select;
        v[USC_B_WK_CONN] = p.wake_connect_enable;
        v[USC_B_WK_DISC] = p.wake_disconnect_enable;
        v[USC_B_WK_OC] = p.wake_overcurrent_enable;
        port_image = v;
    endfunction : port_image

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic powered;
        logic hit;
        next_st = st;
        powered = 1'b0;
        hit = 1'b0;
        next_st.cf_q = configure_done_flag_i;
        next_st.rdata = 32'h0000_0000;
        for (int n = 0; n < NUM_PORTS; n++) begin
            powered = st.port[n].port_power_on || !power_switch_present_i;
            hit = (req_i.addr == port_addr(n));
            // wake events, gated by enables
            next_st.wake[n] =
                (st.port[n].wake_connect_enable && powered && connect_i[n]
                    && !st.port[n].connected)
                || (st.port[n].wake_disconnect_enable && !connect_i[n]
                    && st.port[n].connected)
                || (st.port[n].wake_overcurrent_enable && overcurrent_i[n]
                    && !st.port[n].oc_seen);
            next_st.port[n].oc_seen = overcurrent_i[n];
            // an unpowered port reports nothing
            next_st.port[n].connected = powered && connect_i[n];
            if (!powered || !connect_i[n]) begin
                next_st.port[n].enabled = 1'b0;
            end
            if (hit && !req_i.wr) begin
                next_st.rdata = port_image(st.port[n], line_levels_i[2*n +: 2],
                                           power_switch_present_i);
            end
            if (hit && req_i.wr) begin
                next_st.port[n].port_power_on = req_i.wdata[USC_B_POWER];
                if (powered) begin
                    // plain storage, except enabled, which also needs connect_i high and bit 1 clear
                    next_st.port[n].wake_overcurrent_enable =
                        req_i.wdata[USC_B_WK_OC];
                    next_st.port[n].wake_disconnect_enable = req_i.wdata[USC_B_WK_DISC];
                    next_st.port[n].wake_connect_enable = req_i.wdata[USC_B_WK_CONN];
                    next_st.port[n].port_test_select =
                        req_i.wdata[USC_B_TEST_LO +: 4];
                    next_st.port[n].companion_owns_port = req_i.wdata[USC_B_OWNER];
                    next_st.port[n].enabled = req_i.wdata[USC_B_ENABLE] && connect_i[n]
                        && !req_i.wdata[USC_B_ENABLE - 1];
                end
            end
            // overcurrent drops switched power
            if (power_switch_present_i && st.port[n].port_power_on && overcurrent_i[n]) begin
                next_st.port[n].port_power_on = 1'b0;
                next_st.port[n].enabled = 1'b0;
            end
            // ownership follows the configure flag
            if (!configure_done_flag_i) begin
                next_st.port[n].companion_owns_port = 1'b1;
            end else if (!st.cf_q) begin
                next_st.port[n].companion_owns_port = 1'b0;
            end
        end
        if (hc_reset_i) begin
            for (int n = 0; n < NUM_PORTS; n++) begin
                next_st.port[n] = USC_PORT_RST;
            end
            next_st.wake = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int n = 0; n < NUM_PORTS; n++) begin
                st.port[n] <= USC_PORT_RST;
            end
            st.cf_q <= 1'b0;
            st.rdata <= 32'h0000_0000;
            st.wake <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // outputs
    always_comb begin
        for (int n = 0; n < NUM_PORTS; n++) begin
            port_test_select_o[4*n +: 4] = st.port[n].port_test_select;
            port_power_on_o[n] = st.port[n].port_power_on | ~power_switch_present_i;
            companion_owns_port_o[n] = st.port[n].companion_owns_port;
        end
    end
    assign rdata_o = st.rdata;
    assign wake_o = st.wake;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    // reset values and clock enable
    AST_HCRST_CLEARS: assert property (ce_i && hc_reset_i
        |=> st.port[0] == USC_PORT_RST)
        else $error("port not reset by host controller reset");
    AST_RESET_STATUS: assert property (ce_i && hc_reset_i
        |=> !st.port[0].connected && !st.port[0].enabled)
        else $error("port shows connection after reset");
    AST_CE_FREEZE: assert property (!ce_i |=> $stable(st))
        else $error("state moved while clock enable low");

    // switched power gates port state
    AST_UNPOWERED_FROZEN: assert property (ce_i && power_switch_present_i
        && !st.port[0].port_power_on && !hc_reset_i && configure_done_flag_i && st.cf_q
        |=> $stable(st.port[0].port_test_select))
        else $error("unpowered port state changed");
    AST_OC_POWER: assert property (ce_i && !hc_reset_i && power_switch_present_i
        && st.port[0].port_power_on && overcurrent_i[0] |=> !port_power_on_o[0])
        else $error("overcurrent kept power");

    // address decode
    AST_PORT1_READ: assert property (ce_i && !req_i.wr
        && req_i.addr == USC_PORT_BASE
        |=> rdata_o[USC_B_OWNER] == $past(st.port[0].companion_owns_port))
        else $error("port 1 not decoded at its offset");
    AST_UNMAPPED_ZERO: assert property (ce_i && (req_i.wr
        || (req_i.addr != USC_PORT_BASE && req_i.addr != USC_PORT_BASE + USC_PORT_STRIDE))
        |=> rdata_o == 32'h0000_0000)
        else $error("read data on write or unmapped address");
    if (NUM_PORTS == 2) begin : g_port2_check
        AST_ADDR_PORT2: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
            ce_i && !req_i.wr && req_i.addr == USC_PORT_BASE + USC_PORT_STRIDE
            |=> rdata_o[USC_B_TEST_LO +: 4] == $past(st.port[1].port_test_select))
            else $error("port 2 not decoded at its offset");
    end

    // wake detection
    AST_WAKE_CONN: assert property (ce_i && !hc_reset_i
        && st.port[0].wake_connect_enable && connect_i[0] && !st.port[0].connected
        && (st.port[0].port_power_on || !power_switch_present_i) |=> wake_o[0])
        else $error("connect wake missed");
    AST_WAKE_DISC: assert property (ce_i && !hc_reset_i
        && st.port[0].wake_disconnect_enable && !connect_i[0] && st.port[0].connected
        |=> wake_o[0])
        else $error("disconnect wake missed");
    AST_WAKE_OC: assert property (ce_i && !hc_reset_i
        && st.port[0].wake_overcurrent_enable && overcurrent_i[0] && !st.port[0].oc_seen
        |=> wake_o[0])
        else $error("overcurrent wake missed");
    AST_NO_WAKE: assert property (ce_i && !st.port[0].wake_connect_enable
        && !st.port[0].wake_disconnect_enable && !st.port[0].wake_overcurrent_enable
        |=> !wake_o[0])
        else $error("wake without enable");

    // ownership and plain storage
    AST_OWNER_LOW_CF: assert property (ce_i && !configure_done_flag_i
        |=> companion_owns_port_o[0])
        else $error("owner not forced while flag low");
    AST_OWNER_CF_RISE: assert property (ce_i && !hc_reset_i
        && configure_done_flag_i && !st.cf_q |=> !companion_owns_port_o[0])
        else $error("owner not cleared on flag rise");
    AST_WRITE_STORE: assert property (ce_i && !hc_reset_i && req_i.wr
        && req_i.addr == USC_PORT_BASE
        && (st.port[0].port_power_on || !power_switch_present_i)
        |=> st.port[0].port_test_select == $past(req_i.wdata[USC_B_TEST_LO +: 4])
        && st.port[0].wake_connect_enable == $past(req_i.wdata[USC_B_WK_CONN]))
        else $error("stored field differs from written value");

    // line levels
    AST_LINE_MASK: assert property (ce_i && !req_i.wr
        && req_i.addr == USC_PORT_BASE && st.port[0].enabled
        |=> rdata_o[USC_B_LINE_LO +: 2] == USC_LINE_NONE)
        else $error("line levels shown on enabled port");
    AST_LINE_SHOWN: assert property (ce_i && !req_i.wr
        && req_i.addr == USC_PORT_BASE && st.port[0].connected && !st.port[0].enabled
        |=> rdata_o[USC_B_LINE_LO +: 2] == $past(line_levels_i[1:0]))
        else $error("line levels missing on disabled connected port");
endmodule : usc_port_regs
